// ===== bench/ext_clock_src.sv
// Behavioural external count clock for the timer
`timescale 1ns/1ps
module ext_clock_src #(parameter realtime HALF = 23.0) (
   input wire logic run_i, // Run the clock
   output logic pin_o // Count clock pin
);
   initial pin_o = 1'b0;
   // Stands still while disabled, like a gated crystal output
   always #(HALF) if (run_i) pin_o = ~pin_o;
endmodule // ext_clock_src

// ===== bench/gp_timer_checker.sv
// Assertion checker for the sixteen-bit general timer
`timescale 1ns/1ps
module gp_timer_checker (
   input wire core_clk_i, // clock
   input wire sys_rst_i, // reset
   input wire idle_i, // idle
   input wire ctrl_wr_i, // control write
   input wire [15:0] ctrl_wdata_i, // control data
   input wire count_wr_i, // count write
   input wire [15:0] count_wdata_i, // count data
   input wire flag_clr_i, // flag clear
   input wire [15:0] timer_control_word_o, // control
   input wire [15:0] count_o, // count
   input wire [15:0] period_o, // period
   input wire match_flag_o, // flag
   input wire [3:0] mode_o // mode
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire [15:0] ctl = timer_control_word_o;
   // External ticks sit in a pipeline, so halt checks stay on the internal source
   wire int_src = !ctl[1] && !count_wr_i;
   sequence s_free; !count_wr_i ##1 count_o != $past(count_o); endsequence
   property p_mask; ctrl_wr_i |=> ctl == ($past(ctrl_wdata_i) & 16'ha076); endproperty
   property p_mode; mode_o == (ctl[1] ? (ctl[2] ? 4'h4 : 4'h8) : (ctl[6] ? 4'h2 : 4'h1)); endproperty
   property p_halt; !ctl[15] && int_src |=> $stable(count_o); endproperty
   property p_idle; idle_i && ctl[13] && int_src |=> $stable(count_o); endproperty
   property p_wrap; $rose(match_flag_o) |-> count_o == 16'h0 && $past(count_o) == period_o; endproperty
   property p_clr; flag_clr_i && count_o != period_o |=> !match_flag_o; endproperty
   property p_load; count_wr_i |=> count_o == $past(count_wdata_i); endproperty
   property p_step; s_free |-> count_o == $past(count_o) + 16'h1 || count_o == 16'h0; endproperty
   a_mask: assert property (p_mask) else $error("control readback wrong");
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   a_halt: assert property (p_halt) else $error("count moved while stopped");
   a_idle: assert property (p_idle) else $error("count moved in idle");
   a_wrap: assert property (p_wrap) else $error("flag without period match");
   a_clr: assert property (p_clr) else $error("flag not cleared");
   a_load: assert property (p_load) else $error("count load lost");
   a_step: assert property (p_step) else $error("count step not one");
endmodule // gp_timer_checker
bind gp_timer gp_timer_checker chk (.*);

// ===== bench/testbench.sv
// Self-checking bench for the sixteen-bit general timer
`timescale 1ns/1ps
module testbench;
   logic core_clk_i = 0, sys_rst_i = 1, tick = 0, gate = 0, idle = 0, cwr = 0, kwr = 0, pwr = 0, fclr = 0, run = 0;
   logic [15:0] cdat = 0, kdat = 0, pdat = 0;
   wire pin, flag;
   wire [15:0] ctrl, cnt, per;
   wire [3:0] mode;
   int miscompares = 0, checked = 0, cycles = 0, edges = 0;
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge pin) edges++;
   ext_clock_src src (.run_i(run), .pin_o(pin));
   gp_timer uut (.core_clk_i, .sys_rst_i, .instruction_cycle_clock_i(tick), .external_count_clock_pin_i(pin),
      .gate_i(gate), .idle_i(idle), .ctrl_wr_i(cwr), .ctrl_wdata_i(cdat), .period_wr_i(pwr), .period_wdata_i(pdat),
      .count_wr_i(kwr), .count_wdata_i(kdat), .flag_clr_i(fclr), .timer_control_word_o(ctrl), .count_o(cnt),
      .period_o(per), .match_flag_o(flag), .mode_o(mode));
   task end_sim;
      $display("Checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input [63:0] got, input [63:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // Every write also clears the counter, so each step starts from a known zero
   task wr(input [15:0] c, input [15:0] p = 16'hffff);
      {cdat, kdat, pdat} = {c, 16'h0, p};
      {cwr, kwr, pwr} = 3'h7;
      cyc(1);
      {cwr, kwr, pwr} = 3'h0;
      cyc(1);
   endtask
   task ticks(input int n);
      repeat (n) begin
         tick = 1;
         cyc(1);
         tick = 0;
         cyc(1);
      end
   endtask
   task t_regs;
      logic [15:0] cw [4] = '{16'h0004, 16'h0044, 16'h0046, 16'h0002};
      chk({ctrl, cnt, per, 11'h0, flag, mode}, {32'h0, 16'hffff, 16'h0001});
      wr(16'hffff);
      chk(ctrl, 16'ha076);
      for (int i = 0; i < 4; i++) begin
         wr(cw[i]);
         chk(mode, 4'h1 << i);
      end
   endtask
   task t_timer;
      int div [4] = '{1, 8, 64, 256};
      wr(16'h0000);
      ticks(3);
      chk(cnt, 0);
      wr(16'h8000);
      idle = 1;
      ticks(3);
      chk(cnt, 3);
      wr(16'ha000);
      ticks(2);
      chk(cnt, 0);
      idle = 0;
      wr(16'h8000, 16'h0002);
      chk(per, 16'h0002);
      ticks(3);
      chk({flag, cnt}, 17'h10000);
      fclr = 1;
      cyc(1);
      fclr = 0;
      chk(flag, 0);
      ticks(2);
      {tick, fclr} = 2'b11;
      cyc(1);
      {tick, fclr} = 2'b00;
      cyc(1);
      chk({flag, cnt}, 17'h10000);
      fclr = 1;
      cyc(1);
      fclr = 0;
      chk(flag, 0);
      wr(16'h8040);
      ticks(2);
      gate = 1;
      ticks(2);
      chk(cnt, 2);
      for (int i = 0; i < 4; i++) begin
         wr(16'h0000);
         wr({8'h80, 2'h0, i[1:0], 4'h0});
         ticks(div[i] - 1);
         chk(cnt, 0);
         ticks(1);
         chk(cnt, 1);
      end
   endtask
   task t_ext(input [15:0] c, input bit counts);
      wr(c);
      edges = 0;
      run = 1;
      cyc(40);
      run = 0;
      cyc(10);
      chk(cnt, counts ? edges : 0);
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      cyc(2);
      sys_rst_i = 0;
      t_regs();
      t_timer();
      t_ext(16'h8002, 1);
      t_ext(16'h8006, 1);
      t_ext(16'h8000, 0);
      end_sim();
   end
endmodule // testbench

// ===== rtl/edge_prescaler.v
// Prescaler that turns count ticks into prescaled ticks
`timescale 1ns/1ps
`include "gp_timer_defs.vh"
module edge_prescaler (
   input wire clk_i,         // Clock the ticks belong to
   input wire rst_i,         // Synchronous clear, active high
   input wire tick_i,        // Raw count tick
   input wire [1:0] sel_i,   // Prescale code
   output wire tick_o        // Prescaled tick, combinational
);
   reg [7:0] div_q;
   reg [7:0] last;
   always @* begin
      case (sel_i)
         `PS_DIV8: last = `PS_LAST_DIV8;
         `PS_DIV64: last = `PS_LAST_DIV64;
         `PS_DIV256: last = `PS_LAST_DIV256;
         default: last = 8'h00;
      endcase
   end
   assign tick_o = tick_i && (div_q >= last);
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 8'h00;
      end else if (tick_i) begin
         div_q <= (div_q >= last) ? 8'h00 : div_q + 8'h01;
      end
   end
endmodule // edge_prescaler

// ===== rtl/gp_timer.v
// Sixteen-bit general timer with four count modes
`timescale 1ns/1ps
`include "gp_timer_defs.vh"
module gp_timer (
   input wire core_clk_i,                 // System clock, 200 MHz
   input wire sys_rst_i,                  // Synchronous reset, active high
   input wire instruction_cycle_clock_i,  // One-cycle instruction tick
   input wire external_count_clock_pin_i, // External count clock or crystal
   input wire gate_i,                     // External gate level
   input wire idle_i,                     // Chip is in idle mode
   input wire ctrl_wr_i,                  // Write strobe for the control word
   input wire [15:0] ctrl_wdata_i,        // Control word write data
   input wire period_wr_i,                // Write strobe for the period
   input wire [15:0] period_wdata_i,      // Period write data
   input wire count_wr_i,                 // Write strobe for the counter
   input wire [15:0] count_wdata_i,       // Counter write data
   input wire flag_clr_i,                 // Clears the match flag
   output wire [15:0] timer_control_word_o, // Control word readback
   output wire [15:0] count_o,            // Counter value
   output wire [15:0] period_o,           // Period value
   output wire match_flag_o,              // Sticky period match flag
   output wire [3:0] mode_o               // One-hot active mode
);
   localparam [3:0] MODE_TIMER = 4'h1;
   localparam [3:0] MODE_GATED = 4'h2;
   localparam [3:0] MODE_SYNC = 4'h4;
   localparam [3:0] MODE_ASYNC = 4'h8;

   reg [15:0] tcw_q;
   reg [15:0] count_q;
   reg [15:0] period_q;
   reg flag_q;
   reg [3:0] mode;
   reg ext_s1_q;
   reg ext_s2_q;
   reg ext_s3_q;
   reg raw_tick;
   wire timer_run_enable = tcw_q[`TCW_RUN_BIT];
   wire idle_stop_select = tcw_q[`TCW_IDLE_STOP_BIT];
   wire gated_accumulation_enable = tcw_q[`TCW_GATE_BIT];
   wire external_sync_select = tcw_q[`TCW_SYNC_BIT];
   wire clock_source_select = tcw_q[`TCW_SOURCE_BIT];
   wire [1:0] prescale_select = tcw_q[`TCW_PRESCALE_HI:`TCW_PRESCALE_LO];
   wire active;
   wire ps_tick;
   wire count_event;
   wire match;

   // Edge, hold and clear terms of the count path
   wire ext_rise;
   wire idle_hold;
   wire ps_clear;
   wire sync_tick_d;

   // Next values of the registers
   reg [15:0] tcw_d;
   reg [15:0] period_d;
   reg [15:0] count_d;
   reg flag_d;

   // Mode decode. The source bit picks internal or pin counting; with the
   // internal clock the gate bit picks plain or gated timing, and with the
   // pin the sync bit picks the aligned or the direct path. The codes are
   // one-hot so each mode can be tested with a single bit.
   always @* begin
      if (!clock_source_select) begin
         mode = gated_accumulation_enable ? MODE_GATED : MODE_TIMER;
      end else begin
         mode = external_sync_select ? MODE_SYNC : MODE_ASYNC;
      end
   end

   // Rising edges of the pin; with one clock the pin is sampled here, so
   // the async mode differs only in skipping the post-prescaler stage.
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= external_count_clock_pin_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // A rising edge is a low-to-high step between the last two stages
   assign ext_rise = ext_s2_q && !ext_s3_q;

   // Select the raw tick before the prescaler
   always @* begin
      case (mode)
         MODE_TIMER: raw_tick = instruction_cycle_clock_i;
         MODE_GATED: raw_tick = instruction_cycle_clock_i && gate_i;
         MODE_SYNC: raw_tick = ext_rise;
         MODE_ASYNC: raw_tick = ext_rise;
         default: raw_tick = 1'b0;
      endcase
   end

   // Idle stop only matters while the chip is idle
   assign idle_hold = idle_stop_select && idle_i;
   assign active = timer_run_enable && !idle_hold;

   // Clearing the prescaler while run enable is off makes every run start begin a fresh
   // divide period, so the first prescaled tick is never early.
   assign ps_clear = sys_rst_i || !timer_run_enable;

   edge_prescaler u_prescaler (
      .clk_i(core_clk_i),
      .rst_i(ps_clear),
      .tick_i(raw_tick && active),
      .sel_i(prescale_select),
      .tick_o(ps_tick)
   );

   // Sync mode realigns the prescaled tick one clock later; async
   // mode uses the prescaler output directly.
   assign sync_tick_d = ps_tick && (mode == MODE_SYNC);
   reg ps_tick_q;
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ps_tick_q <= 1'b0;
      end else begin
         ps_tick_q <= sync_tick_d;
      end
   end
   assign count_event = (mode == MODE_SYNC) ? ps_tick_q : ps_tick;

   // A match needs a count event, so writing a period equal to the
   // current count does not trip it until the next count arrives.
   assign match = count_event && (count_q == period_q);

   // Next control word: unimplemented bits never reach the register, so
   // they always read back as zero.
   always @* begin
      tcw_d = tcw_q;
      if (ctrl_wr_i) begin
         tcw_d = ctrl_wdata_i & `TCW_WRITE_MASK;
      end
   end

   // Next period value; it takes effect for the very next compare.
   // A period write alone never sets the flag.
   always @* begin
      period_d = period_q;
      if (period_wr_i) begin
         period_d = period_wdata_i;
      end
   end

   // Next counter value. A software write takes priority over a count in
   // the same cycle, so a load is never half overwritten by an increment;
   // the count that falls in that cycle is lost on purpose.
   always @* begin
      count_d = count_q;
      if (count_wr_i) begin
         count_d = count_wdata_i;
      end else if (match) begin
         count_d = `COUNT_RESET;
      end else if (count_event) begin
         count_d = count_q + 16'h0001;
      end
   end

   // Next flag value. A match in the clear cycle still sets the flag, so
   // software clearing late can never lose a period event.
   always @* begin
      flag_d = flag_q;
      if (match) begin
         flag_d = 1'b1;
      end else if (flag_clr_i) begin
         flag_d = 1'b0;
      end
   end

   // Control word register
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tcw_q <= `TCW_RESET;
      end else begin
         tcw_q <= tcw_d;
      end
   end

   // Period register; its reset value lets a fresh timer span all 16 bits
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         period_q <= `PERIOD_RESET;
      end else begin
         period_q <= period_d;
      end
   end

   // Counter register
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_q <= `COUNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // Sticky match flag register
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Outputs come straight from the registers; mode is a decode of them
   assign timer_control_word_o = tcw_q;
   assign count_o = count_q;
   assign period_o = period_q;
   assign match_flag_o = flag_q;
   assign mode_o = mode;
endmodule // gp_timer

// ===== rtl/gp_timer_defs.vh
// Constants of the sixteen-bit general timer
// Notes on behaviour
// - One 16-bit counter steps on qualified events
// - Serves as clock time base or interval timer
// - Low-power 32 kHz crystal may drive counting
// - Asynchronous counter mode skips clock alignment
// - Optional alignment happens after the prescaler
// - Timer and gated modes count instruction cycles
// - Counter modes count the external clock pin
// - Mode bits: source 1, sync 2, gate 6
// - Source, gate and sync pick the mode
// - Counts only while run enable is set
// - Prescale codes give 1, 8, 64, 256
// - External clock counts on its rising edge
// - Idle-stop bit halts timer during idle
`ifndef GP_TIMER_DEFS_VH
`define GP_TIMER_DEFS_VH
`define TCW_RUN_BIT 15
`define TCW_IDLE_STOP_BIT 13
`define TCW_GATE_BIT 6
`define TCW_PRESCALE_HI 5
`define TCW_PRESCALE_LO 4
`define TCW_SYNC_BIT 2
`define TCW_SOURCE_BIT 1
`define TCW_WRITE_MASK 16'ha076
`define TCW_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'hffff
`define PS_DIV1 2'h0
`define PS_DIV8 2'h1
`define PS_DIV64 2'h2
`define PS_DIV256 2'h3
`define PS_LAST_DIV8 8'h07
`define PS_LAST_DIV64 8'h3f
`define PS_LAST_DIV256 8'hff
`endif
